//--- design/ccb_master.sv
`timescale 1ns/1ps
module ccb_master
  import ccb_pkg::*;
#(
  parameter int TIMEOUT = TIMEOUT_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  // User side: start a cycle
  input wire logic start_i,
  output logic start_ready_o,
  input wire logic broadcast_i,
  input wire logic [CTRL_W-1:0] addr_ctrl_i,
  input wire logic [TAG_W-1:0] addr_tag_i,
  input wire logic [DATA_W-1:0] addr_data_i,
  // User side: transfer commands
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic cmd_last_i,
  input wire logic [CTRL_W-1:0] cmd_ctrl_i,
  input wire logic [TAG_W-1:0] cmd_tag_i,
  input wire logic [DATA_W-1:0] cmd_data_i,
  // User side: per transfer result
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_data_o,
  output logic rsp_error_o,
  output logic rsp_timeout_o,
  output logic busy_o,
  // Cable side
  output logic address_strobe_o,
  output logic data_strobe_o,
  input wire logic wait_i,
  input wire logic slave_error_flag_i,
  output logic [CTRL_W-1:0] control_lines_o,
  output logic [TAG_W-1:0] source_tag_lines_o,
  output logic [DATA_W-1:0] mux_lines_o,
  output logic mux_lines_oe_o,
  input wire logic [DATA_W-1:0] mux_lines_i
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ASETUP = 4'h1,
    ST_AHOLD = 4'h2,
    ST_FETCH = 4'h3,
    ST_DSETUP = 4'h4,
    ST_WAITHI = 4'h5,
    ST_WAITLO = 4'h6,
    ST_GAP = 4'h7,
    ST_END = 4'h8
  } ccb_state_e;

  ccb_state_e st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] tmo_r, tmo_nxt;
  logic bcast_r, bcast_nxt;
  logic wr_r, wr_nxt, last_r, last_nxt, err_r, err_nxt;
  logic as_r, as_nxt, dstb_r, dstb_nxt, oe_r, oe_nxt;
  logic [CTRL_W-1:0] ctl_r, ctl_nxt;
  logic [TAG_W-1:0] tag_r, tag_nxt;
  logic [DATA_W-1:0] ad_r, ad_nxt;
  logic rv_r, rv_nxt, re_r, re_nxt, rt_r, rt_nxt;
  logic [DATA_W-1:0] rd_r, rd_nxt;
  logic [1:0] wait_s, err_s;
  logic [DATA_W-1:0] ad_s1, ad_s2;
  logic wait_q, err_q, f_valid, f_ready;
  logic [CMD_W-1:0] f_data, cmd_word;

  ////////////////////////////////////////////////////////////////////////
  // Cable inputs pass two flops before use
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wait_s <= '0;
      err_s <= '0;
      ad_s1 <= '0;
      ad_s2 <= '0;
    end
    else
    begin
      wait_s <= {wait_s[0], wait_i};
      err_s <= {err_s[0], slave_error_flag_i};
      ad_s1 <= mux_lines_i;
      ad_s2 <= ad_s1;
    end
  end
  assign wait_q = wait_s[1];
  assign err_q = err_s[1];

  ////////////////////////////////////////////////////////////////////////
  // Command FIFO: back-pressure reaches the user
  assign cmd_word = {cmd_last_i, cmd_write_i, cmd_ctrl_i, cmd_tag_i,
                     cmd_data_i};
  assign f_ready = (st_r == ST_FETCH);

  ccb_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(cmd_valid_i),
    .in_ready_o(cmd_ready_o),
    .in_data_i(cmd_word),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Cycle sequencer
  assign start_ready_o = (st_r == ST_IDLE);

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r == '0) ? '0 : cnt_r - 1'b1;
    tmo_nxt = tmo_r;
    bcast_nxt = bcast_r;
    wr_nxt = wr_r;
    last_nxt = last_r;
    err_nxt = err_r;
    as_nxt = as_r;
    dstb_nxt = dstb_r;
    oe_nxt = oe_r;
    ctl_nxt = ctl_r;
    tag_nxt = tag_r;
    ad_nxt = ad_r;
    rv_nxt = 1'b0;
    re_nxt = re_r;
    rt_nxt = rt_r;
    rd_nxt = rd_r;
    unique case (st_r)
      ST_IDLE:
      begin
        if (start_i)
        begin
          ctl_nxt = addr_ctrl_i;
          tag_nxt = addr_tag_i;
          ad_nxt = addr_data_i;
          oe_nxt = 1'b1;
          bcast_nxt = broadcast_i;
          err_nxt = 1'b0;
          cnt_nxt = CNT_W'(ADDR_SETUP_CYC);
          st_nxt = ST_ASETUP;
        end
      end
      ST_ASETUP:
      begin
        if (cnt_r == '0)
        begin
          as_nxt = 1'b1;
          cnt_nxt = CNT_W'(ADDR_HOLD_CYC);
          st_nxt = ST_AHOLD;
        end
      end
      ST_AHOLD:
      begin
        if (cnt_r == '0)
        begin
          // No wait for WAIT here
          ctl_nxt = '0;
          tag_nxt = '0;
          oe_nxt = 1'b0;
          st_nxt = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        // Cycle stays open across transfers in any order
        if (f_valid)
        begin
          wr_nxt = f_data[CMD_WR];
          last_nxt = f_data[CMD_LAST];
          ctl_nxt = f_data[DATA_W+TAG_W +: CTRL_W];
          ctl_nxt[DIR_BIT] = f_data[CMD_WR];
          tag_nxt = f_data[DATA_W +: TAG_W];
          ad_nxt = f_data[DATA_W-1:0];
          oe_nxt = f_data[CMD_WR];
          cnt_nxt = CNT_W'(DATA_SETUP_CYC);
          st_nxt = ST_DSETUP;
        end
      end
      ST_DSETUP:
      begin
        // Gap after a previous transfer was served in ST_GAP before reaching here
        if (cnt_r == '0)
        begin
          dstb_nxt = 1'b1;
          tmo_nxt = CNT_W'(TIMEOUT);
          st_nxt = ST_WAITHI;
        end
      end
      ST_WAITHI, ST_WAITLO:
      begin
        tmo_nxt = tmo_r - 1'b1;
        if (st_r == ST_WAITHI && wait_q)
        begin
          cnt_nxt = CNT_W'(GLITCH_CYC);
          st_nxt = ST_WAITLO;
        end
        else if (st_r == ST_WAITLO && wait_q)
          cnt_nxt = CNT_W'(GLITCH_CYC);
        else if (st_r == ST_WAITLO && (!bcast_r || cnt_r == '0))
        begin
          rd_nxt = wr_r ? rd_r : ad_s2;
          re_nxt = err_q;
          rt_nxt = 1'b0;
          rv_nxt = 1'b1;
          if (err_q || !wr_r)
            err_nxt = 1'b1;
          else
            err_nxt = 1'b0;
          dstb_nxt = 1'b0;
          oe_nxt = 1'b0;
          cnt_nxt = CNT_W'(STROBE_GAP_CYC);
          st_nxt = ST_GAP;
        end
        if (tmo_r == '0)
        begin
          // A dead slave must not hang the cable
          rv_nxt = 1'b1;
          rt_nxt = 1'b1;
          re_nxt = 1'b1;
          err_nxt = 1'b1;
          dstb_nxt = 1'b0;
          oe_nxt = 1'b0;
          last_nxt = 1'b1;
          cnt_nxt = CNT_W'(STROBE_GAP_CYC);
          st_nxt = ST_GAP;
        end
      end
      ST_GAP:
      begin
        if (last_r)
        begin
          cnt_nxt = err_r ? CNT_W'(END_LONG_CYC)
                          : CNT_W'(END_SHORT_CYC);
          st_nxt = ST_END;
        end
        else if (cnt_r == '0)
          st_nxt = ST_FETCH;
      end
      ST_END:
      begin
        if (cnt_r == '0)
        begin
          as_nxt = 1'b0;
          ctl_nxt = '0;
          tag_nxt = '0;
          st_nxt = ST_IDLE;
        end
      end
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      tmo_r <= '0;
      bcast_r <= 1'b0;
      wr_r <= 1'b0;
      last_r <= 1'b0;
      err_r <= 1'b0;
      as_r <= 1'b0;
      dstb_r <= 1'b0;
      oe_r <= 1'b0;
      ctl_r <= '0;
      tag_r <= '0;
      ad_r <= '0;
      rv_r <= 1'b0;
      re_r <= 1'b0;
      rt_r <= 1'b0;
      rd_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      tmo_r <= tmo_nxt;
      bcast_r <= bcast_nxt;
      wr_r <= wr_nxt;
      last_r <= last_nxt;
      err_r <= err_nxt;
      as_r <= as_nxt;
      dstb_r <= dstb_nxt;
      oe_r <= oe_nxt;
      ctl_r <= ctl_nxt;
      tag_r <= tag_nxt;
      ad_r <= ad_nxt;
      rv_r <= rv_nxt;
      re_r <= re_nxt;
      rt_r <= rt_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign address_strobe_o = as_r;
  assign data_strobe_o = dstb_r;
  assign control_lines_o = ctl_r;
  assign source_tag_lines_o = tag_r;
  assign mux_lines_o = ad_r;
  assign mux_lines_oe_o = oe_r;
  assign rsp_valid_o = rv_r;
  assign rsp_data_o = rd_r;
  assign rsp_error_o = re_r;
  assign rsp_timeout_o = rt_r;
  assign busy_o = (st_r != ST_IDLE);
endmodule // ccb_master

//--- shared/ccb_pkg.sv
package ccb_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // Bus timing figures in ns; plain defaults, tunable per installation
  localparam int ADDR_SETUP_NS = 40;
  localparam int ADDR_HOLD_NS = 40;
  localparam int DATA_SETUP_NS = 40;
  localparam int STROBE_GAP_NS = 120;
  localparam int CABLE_PROP_NS = 50;
  localparam int SLAVE_RELEASE_NS = 80;
  localparam int DS_AS_SKEW_NS = 40;
  localparam int TIMEOUT_NS = 20000;
  // Least times round up to whole cycles
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int ADDR_SETUP_CYC = ns_to_cyc(ADDR_SETUP_NS);
  localparam int ADDR_HOLD_CYC = ns_to_cyc(ADDR_HOLD_NS);
  localparam int DATA_SETUP_CYC = ns_to_cyc(DATA_SETUP_NS);
  localparam int STROBE_GAP_CYC = ns_to_cyc(STROBE_GAP_NS);
  localparam int GLITCH_CYC = ns_to_cyc(2 * CABLE_PROP_NS);
  localparam int END_SHORT_CYC = ns_to_cyc(DS_AS_SKEW_NS);
  localparam int END_LONG_CYC =
    ns_to_cyc(2 * CABLE_PROP_NS + SLAVE_RELEASE_NS);
  localparam int TIMEOUT_CYC = ns_to_cyc(TIMEOUT_NS);
  localparam int CNT_W = 16;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 4;
  localparam int TAG_W = 5;
  localparam int DIR_BIT = 2;
  localparam int FIFO_DEPTH = 4;
  // Command word layout: {last, write, ctrl, tag, data}
  localparam int CMD_W = 2 + CTRL_W + TAG_W + DATA_W;
  localparam int CMD_LAST = CMD_W - 1;
  localparam int CMD_WR = CMD_W - 2;
endpackage

//--- design/ccb_fifo.sv
`timescale 1ns/1ps
module ccb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rd_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      mem_nxt[wr_r] = in_data_i;
      wr_nxt = bump(wr_r);
    end
    if (pop)
      rd_nxt = bump(rd_r);
    if (push && !pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    mem_r <= mem_nxt;
    if (rst_i)
    begin
      rd_r <= '0;
      wr_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // ccb_fifo

//--- verif/ccb_master_asserts.sv
`timescale 1ns/1ps
module ccb_master_chk
  import ccb_pkg::*;
(
  input logic clock_i,
  input logic rst_i,
  input logic rsp_valid_o,
  input logic rsp_timeout_o,
  input logic address_strobe_o,
  input logic data_strobe_o,
  input logic wait_i,
  input logic [CTRL_W-1:0] control_lines_o,
  input logic mux_lines_oe_o
);
  logic [CNT_W-1:0] low_r;
  logic [CNT_W-1:0] low_nxt;
  // Cycles the data strobe has been low, saturating
  always_comb
  begin
    low_nxt = data_strobe_o ? '0 : ((&low_r) ? low_r : low_r + 1'b1);
  end
  always_ff @(posedge clock_i)
  begin
    low_r <= rst_i ? '0 : low_nxt;
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_strobe_up;
    $rose(data_strobe_o);
  endsequence
  sequence s_xfer_end;
    $fell(data_strobe_o) ##0 rsp_valid_o;
  endsequence
  a_ds_in_as: assert property (data_strobe_o |-> address_strobe_o)
    else $error("data strobe outside cycle");
  a_read_released: assert property (data_strobe_o &&
    !control_lines_o[DIR_BIT] |-> !mux_lines_oe_o)
    else $error("lines driven on read");
  a_write_driven: assert property (data_strobe_o &&
    control_lines_o[DIR_BIT] |-> mux_lines_oe_o)
    else $error("lines not driven on write");
  a_addr_setup: assert property ($rose(address_strobe_o) |->
    $past(mux_lines_oe_o, ADDR_SETUP_CYC))
    else $error("address set-up short");
  a_addr_hold: assert property ($rose(address_strobe_o) |->
    mux_lines_oe_o [*5])
    else $error("address hold short");
  a_strobe_gap: assert property (s_strobe_up |->
    low_r >= STROBE_GAP_CYC - 1)
    else $error("strobe gap short");
  a_end_hold: assert property ($fell(address_strobe_o) |->
    low_r >= END_SHORT_CYC)
    else $error("end hold short");
  a_read_end_long: assert property ($fell(address_strobe_o) &&
    !$past(control_lines_o[DIR_BIT]) |-> low_r >= END_LONG_CYC)
    else $error("read end hold short");
  a_rsp_at_drop: assert property ($rose(rsp_valid_o) |-> s_xfer_end)
    else $error("response not at strobe drop");
  a_wait_seen_low: assert property (s_xfer_end ##0 !rsp_timeout_o |->
    $past(wait_i, 2) == 1'b0)
    else $error("strobe dropped before wait release");
endmodule // ccb_master_chk
bind ccb_master ccb_master_chk chk_u (.clock_i, .rst_i, .rsp_valid_o,
  .rsp_timeout_o, .address_strobe_o, .data_strobe_o, .wait_i,
  .control_lines_o, .mux_lines_oe_o);

//--- verif/ccb_slave_model.sv
`timescale 1ns/1ps
module ccb_slave_model
  import ccb_pkg::*;
#(
  parameter logic [TAG_W-1:0] DEV_TAG = 5'h03
) (
  input logic clock_i,
  input logic rst_i,
  input logic as_i,
  input logic dstrobe_i,
  input logic [CTRL_W-1:0] ctrl_i,
  input logic [TAG_W-1:0] tag_i,
  input logic [DATA_W-1:0] m_data_i,
  input logic m_oe_i,
  input int delay_i,
  input logic err_i,
  output logic wait_o,
  output logic slave_error_flag_o,
  output logic [DATA_W-1:0] bus_o
);
  logic [DATA_W-1:0] mem [4];
  logic [DATA_W-1:0] s_data;
  logic as_q, dstrobe_q, sel, s_oe, wr;
  logic [1:0] loc;
  int cnt;
  // Released lines show the inverse of the last value
  assign bus_o = m_oe_i ? m_data_i : (s_oe ? s_data : ~s_data);
  always @(posedge clock_i)
  begin
    as_q <= as_i;
    dstrobe_q <= dstrobe_i;
    if (rst_i)
    begin
      wait_o <= 1'h0;
      slave_error_flag_o <= 1'h0;
      s_oe <= 1'h0;
      sel <= 1'h0;
      cnt <= 0;
      s_data <= '0;
      mem <= '{default: '0};
    end
    else
    begin
      if (as_i && !as_q)
      begin
        sel <= (tag_i == DEV_TAG);
        loc <= bus_o[1:0];
      end
      if (dstrobe_i && !dstrobe_q && sel)
      begin
        wait_o <= 1'h1;
        cnt <= delay_i + 1;
        wr <= ctrl_i[DIR_BIT];
      end
      else if (cnt > 1)
        cnt <= cnt - 1;
      else if (cnt == 1)
      begin
        cnt <= 0;
        slave_error_flag_o <= err_i;
        s_oe <= !wr;
        if (!wr)
          s_data <= mem[loc];
        else if (!err_i)
          mem[loc] <= m_data_i;
      end
      else if (wait_o)
        wait_o <= 1'h0;
      if (!dstrobe_i && dstrobe_q)
      begin
        s_oe <= 1'h0;
        slave_error_flag_o <= 1'h0;
      end
    end
  end
endmodule // ccb_slave_model

//--- verif/ccb_master_tb.sv
`timescale 1ns/1ps
module ccb_master_tb
  import ccb_pkg::*;
();
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic start_i = 1'h0, broadcast_i = 1'h0, cmd_valid_i = 1'h0;
  logic cmd_write_i = 1'h0, cmd_last_i = 1'h0, s_err = 1'h0;
  logic [TAG_W-1:0] addr_tag_i = 5'h03;
  logic [DATA_W-1:0] addr_data_i = '0, cmd_data_i = '0;
  logic start_ready_o, cmd_ready_o, rsp_valid_o, rsp_error_o, rsp_timeout_o;
  logic busy_o, address_strobe_o, data_strobe_o, wait_i, slave_error_flag_i;
  logic mux_lines_oe_o;
  logic [CTRL_W-1:0] control_lines_o;
  logic [TAG_W-1:0] source_tag_lines_o;
  logic [DATA_W-1:0] rsp_data_o, mux_lines_o, mux_lines_i;
  int slow = 0;
  int n_mismatch = 0;
  int tests_run = 0;
  always #4 clock_i = ~clock_i;
  ccb_master #(.TIMEOUT(64)) dut_u (.clock_i, .rst_i, .start_i,
    .start_ready_o, .broadcast_i, .addr_ctrl_i(4'h0), .addr_tag_i,
    .addr_data_i, .cmd_valid_i, .cmd_ready_o, .cmd_write_i, .cmd_last_i,
    .cmd_ctrl_i(4'hf), .cmd_tag_i(5'h03), .cmd_data_i, .rsp_valid_o,
    .rsp_data_o, .rsp_error_o, .rsp_timeout_o, .busy_o, .address_strobe_o,
    .data_strobe_o, .wait_i, .slave_error_flag_i, .control_lines_o,
    .source_tag_lines_o, .mux_lines_o, .mux_lines_oe_o, .mux_lines_i);
  ccb_slave_model slave_u (.clock_i, .rst_i, .as_i(address_strobe_o),
    .dstrobe_i(data_strobe_o), .ctrl_i(control_lines_o),
    .tag_i(source_tag_lines_o), .m_data_i(mux_lines_o),
    .m_oe_i(mux_lines_oe_o), .delay_i(slow), .err_i(s_err),
    .wait_o(wait_i), .slave_error_flag_o(slave_error_flag_i),
    .bus_o(mux_lines_i));
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'h1)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task push(input logic w, input logic l, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    cmd_valid_i <= 1'h1;
    cmd_write_i <= w;
    cmd_last_i <= l;
    cmd_data_i <= d;
    @(negedge clock_i);
    while (cmd_ready_o !== 1'h1)
      @(negedge clock_i);
    @(posedge clock_i);
    cmd_valid_i <= 1'h0;
  endtask
  task start_cyc(input logic [TAG_W-1:0] tag, input logic [1:0] ad,
    input logic bc);
    @(posedge clock_i);
    start_i <= 1'h1;
    addr_tag_i <= tag;
    addr_data_i <= {30'h0, ad};
    broadcast_i <= bc;
    @(negedge clock_i);
    while (start_ready_o !== 1'h1)
      @(negedge clock_i);
    @(posedge clock_i);
    start_i <= 1'h0;
  endtask
  task get_rsp(input logic rd, input logic e, input logic t,
    input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    @(negedge clock_i);
    while (rsp_valid_o !== 1'h1 && k < 3000)
    begin
      @(negedge clock_i);
      k++;
    end
    chk(k < 3000, "no response");
    chk(rsp_error_o === e && rsp_timeout_o === t, "status");
    if (rd)
      chk(rsp_data_o === d, "read data");
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_rmw;
    push(1'h0, 1'h0, '0);
    push(1'h1, 1'h1, 32'h5a5a_00c3);
    start_cyc(5'h03, 2'h1, 1'h0);
    get_rsp(1'h1, 1'h0, 1'h0, 32'h0);
    get_rsp(1'h0, 1'h0, 1'h0, '0);
    push(1'h0, 1'h1, '0);
    start_cyc(5'h03, 2'h1, 1'h0);
    get_rsp(1'h1, 1'h0, 1'h0, 32'h5a5a_00c3);
    $display("test rmw done");
  endtask
  task t_err;
    @(posedge clock_i);
    s_err <= 1'h1;
    push(1'h1, 1'h1, 32'h0000_ffff);
    start_cyc(5'h03, 2'h2, 1'h0);
    get_rsp(1'h0, 1'h1, 1'h0, '0);
    @(posedge clock_i);
    s_err <= 1'h0;
    push(1'h0, 1'h1, '0);
    start_cyc(5'h03, 2'h2, 1'h0);
    get_rsp(1'h1, 1'h0, 1'h0, 32'h0);
    $display("test error done");
  endtask
  task t_timeout;
    push(1'h0, 1'h1, '0);
    start_cyc(5'h1e, 2'h0, 1'h0);
    get_rsp(1'h0, 1'h1, 1'h1, '0);
    repeat (END_SHORT_CYC + 3) @(negedge clock_i);
    chk(busy_o === 1'h1 && address_strobe_o === 1'h1,
      "timeout cycle closed early");
    repeat (END_LONG_CYC - END_SHORT_CYC) @(negedge clock_i);
    chk(busy_o === 1'h0 && address_strobe_o === 1'h0,
      "timeout cycle not closed");
    $display("test timeout done");
  endtask
  task t_fifo;
    @(posedge clock_i);
    slow <= 20;
    for (int i = 0; i < 4; i++)
      push(1'h1, i == 3, 32'h0000_0010 + i);
    @(negedge clock_i);
    chk(cmd_ready_o === 1'h0, "fifo not full");
    start_cyc(5'h03, 2'h3, 1'h1);
    for (int i = 0; i < 4; i++)
      get_rsp(1'h0, 1'h0, 1'h0, '0);
    chk(cmd_ready_o === 1'h1, "fifo not drained");
    push(1'h0, 1'h1, '0);
    start_cyc(5'h03, 2'h3, 1'h0);
    get_rsp(1'h1, 1'h0, 1'h0, 32'h0000_0013);
    $display("test fifo done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'h0;
    t_rmw();
    t_err();
    t_timeout();
    t_fifo();
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    test_done();
  end
endmodule // ccb_master_tb
